/* scsc_pkg.sv */
// Purpose: shared constants and types of the system clock select control block
// Assumes: AXI4-Lite register access, one 125 MHz clock
// Notes: register offsets are byte addresses of aligned 32-bit words
package scsc_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_OSC_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_UNLOCK = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CFG_STATUS = 8'h08;
    // source codes
    localparam logic [2:0] SRC_FAST_RC = 3'h0;
    localparam logic [2:0] SRC_FAST_RC_PLL = 3'h1;
    localparam logic [2:0] SRC_PRIMARY = 3'h2;
    localparam logic [2:0] SRC_PRIMARY_PLL = 3'h3;
    localparam logic [2:0] SRC_SECONDARY = 3'h4;
    localparam logic [2:0] SRC_LOW_POWER_RC = 3'h5;
    localparam logic [2:0] SRC_RESERVED = 3'h6;
    localparam logic [2:0] SRC_FAST_RC_POST = 3'h7;
    // primary modes
    localparam logic [1:0] PMODE_EXT_CLOCK = 2'h0;
    localparam logic [1:0] PMODE_XT = 2'h1;
    localparam logic [1:0] PMODE_HS = 2'h2;
    localparam logic [1:0] PMODE_NONE = 2'h3;
    // control register fields
    localparam int BIT_REQ = 0;
    localparam int BIT_SEC_EN = 1;
    localparam int BIT_KEEP = 2;
    localparam int BIT_FAIL = 3;
    localparam int BIT_PLL_LOCK = 5;
    localparam int BIT_PIN_LOCK = 6;
    localparam int BIT_SEL_LOCK = 7;
    localparam int NEW_LSB = 8;
    localparam int CUR_LSB = 12;
    // configuration word two fields
    localparam int CFG_PMODE_LSB = 0;
    localparam int CFG_ONE_WAY_BIT = 4;
    localparam int CFG_PIN_FN_BIT = 5;
    localparam int CFG_SWMON_LSB = 6;
    localparam int CFG_INIT_LSB = 8;
    localparam logic [15:0] CFG_ERASED = 16'hFFFF;
    localparam logic [1:0] CFG_LOAD_AT = 2'h2;
    // unlock keys, written in order to the unlock register
    localparam logic [7:0] UNLOCK_KEY1 = 8'h5A;
    localparam logic [7:0] UNLOCK_KEY2 = 8'hA5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int FAST_RC_HZ = 8000000;
    localparam int USB_CLOCK_HZ = 48000000;
    localparam int PLL_OUT_HZ = 96000000;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_COMMIT = 3'b100
    } scsc_state_type;
endpackage

/* scsc_sync.sv */
// Purpose: two-flop synchroniser for inputs from outside the clock domain
// Assumes: each bit is an independent level
// Notes: multi-bit words are only safe when quasi-static, as the config word is
`timescale 1ns/1ns
module scsc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // scsc_sync

/* scsc_top.sv */
// Purpose: oscillator source selection, switching, locks and status
// Assumes: oscillators and PLL are analog, reached through enable and ready pins
// Notes: all control register writes need a fresh unlock sequence
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
module scsc_top
    import scsc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] config_word_two,
    input wire logic pll_locked,
    input wire logic clock_fail_detect,
    input wire logic target_osc_ready,
    input wire logic sleep_mode,
    output logic [2:0] sys_source_q,
    output logic [2:0] switch_target_q,
    output logic switch_active_q,
    output logic pll_enable_q,
    output logic usb_clock_enable_q,
    output logic fast_rc_run_q,
    output logic fast_rc_div_enable_q,
    output logic primary_osc_run_q,
    output logic secondary_osc_run_q,
    output logic instruction_clock_q,
    output logic osc_output_pin_q,
    output logic osc_output_pin_oe_q,
    output logic monitor_enable_q
);
    // ==========================================================
    // input synchronisers
    logic [18:0] sync_q;
    logic [15:0] cfg_s;
    logic pll_locked_s;
    logic fail_s;
    logic osc_ready_s;

    scsc_sync #(.WIDTH(19)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({config_word_two, pll_locked, clock_fail_detect, target_osc_ready}),
        .q(sync_q)
    );
    assign cfg_s = sync_q[18:3];
    assign pll_locked_s = sync_q[2];
    assign fail_s = sync_q[1];
    assign osc_ready_s = sync_q[0];

    // ==========================================================
    // configuration capture after reset release
    logic [1:0] load_cnt_q;
    logic cfg_loaded_q;
    logic [15:0] cfg_q;
    logic switch_en_q;
    logic [1:0] pmode;
    logic [2:0] init_src;
    logic load_now;

    assign load_now = !cfg_loaded_q && load_cnt_q == CFG_LOAD_AT;
    assign pmode = cfg_q[CFG_PMODE_LSB +: 2];
    assign init_src = cfg_q[CFG_INIT_LSB +: 3];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            load_cnt_q <= 2'h0;
            cfg_loaded_q <= 1'b0;
            cfg_q <= CFG_ERASED;
            switch_en_q <= 1'b0;
            monitor_enable_q <= 1'b0;
        end else begin
            if (!cfg_loaded_q) begin
                load_cnt_q <= load_cnt_q + 2'h1;
            end
            if (load_now) begin
                cfg_loaded_q <= 1'b1;
                cfg_q <= cfg_s;
                switch_en_q <= !cfg_s[CFG_SWMON_LSB + 1];
                monitor_enable_q <= cfg_s[CFG_SWMON_LSB +: 2] == 2'h0;
            end
        end
    end

    // ==========================================================
    // register bus: write channel
    logic aw_full_q;
    logic w_full_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    logic wr_ctrl;
    logic wr_unlock;
    logic wr_ok;

    assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
    assign wr_ctrl = wr_fire && aw_addr_q[ADDR_W-1:2] == OFS_OSC_CONTROL[ADDR_W-1:2];
    assign wr_unlock = wr_fire && aw_addr_q[ADDR_W-1:2] == OFS_UNLOCK[ADDR_W-1:2];
    assign wr_ok = wr_ctrl || wr_unlock || aw_addr_q[ADDR_W-1:2] == OFS_CFG_STATUS[ADDR_W-1:2];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ==========================================================
    // unlock sequence: key1 then key2 arms exactly one control write
    logic key1_seen_q;
    logic unlocked_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            key1_seen_q <= 1'b0;
            unlocked_q <= 1'b0;
        end else if (wr_unlock) begin
            key1_seen_q <= w_strb_q[0] && w_data_q[7:0] == UNLOCK_KEY1;
            unlocked_q <= key1_seen_q && w_strb_q[0] && w_data_q[7:0] == UNLOCK_KEY2;
        end else if (wr_ctrl) begin
            key1_seen_q <= 1'b0;
            unlocked_q <= 1'b0;
        end
    end

    // ==========================================================
    // control register fields
    logic wr_hi;
    logic wr_lo;
    logic [2:0] cur_src_q;
    logic [2:0] new_src_q;
    logic req_q;
    logic sel_lock_q;
    logic pin_lock_q;
    logic pll_status_q;
    logic fail_flag_q;
    logic keep_q;
    logic sec_en_q;
    scsc_state_type state_q;
    logic req_clear;

    assign wr_hi = wr_ctrl && unlocked_q && w_strb_q[1];
    assign wr_lo = wr_ctrl && unlocked_q && w_strb_q[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            new_src_q <= SRC_FAST_RC_POST;
        end else if (load_now) begin
            new_src_q <= cfg_s[CFG_INIT_LSB +: 3];
        end else if (wr_hi) begin
            new_src_q <= w_data_q[NEW_LSB +: 3];
        end
    end

    // set wins over hardware clear; never set while switching is disabled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_q <= 1'b0;
        end else if (wr_lo && w_data_q[BIT_REQ] && switch_en_q) begin
            req_q <= 1'b1;
        end else if (req_clear || !switch_en_q) begin
            req_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_lock_q <= 1'b0;
            pin_lock_q <= 1'b0;
            keep_q <= 1'b0;
            sec_en_q <= 1'b0;
        end else if (wr_lo) begin
            sel_lock_q <= sel_lock_q || w_data_q[BIT_SEL_LOCK];
            if (!(pin_lock_q && cfg_q[CFG_ONE_WAY_BIT])) begin
                pin_lock_q <= w_data_q[BIT_PIN_LOCK];
            end
            keep_q <= w_data_q[BIT_KEEP];
            sec_en_q <= w_data_q[BIT_SEC_EN];
        end
    end

    // failure wins over a clearing write in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fail_flag_q <= 1'b0;
        end else if (monitor_enable_q && fail_s) begin
            fail_flag_q <= 1'b1;
        end else if (wr_lo && !w_data_q[BIT_FAIL]) begin
            fail_flag_q <= 1'b0;
        end
    end

    // ==========================================================
    // switch sequencer
    logic req_go;
    logic locked_now;
    logic target_pll;
    logic cur_pll;

    assign locked_now = sel_lock_q && monitor_enable_q;
    assign req_go = req_q && switch_en_q && cfg_loaded_q && state_q == ST_IDLE;
    assign req_clear = (req_go && (locked_now || new_src_q == SRC_RESERVED)) || state_q == ST_COMMIT;
    assign target_pll = switch_target_q == SRC_FAST_RC_PLL || switch_target_q == SRC_PRIMARY_PLL;
    assign cur_pll = cur_src_q == SRC_FAST_RC_PLL || cur_src_q == SRC_PRIMARY_PLL;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            switch_target_q <= SRC_FAST_RC_POST;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (req_go && !locked_now && new_src_q != SRC_RESERVED) begin
                        switch_target_q <= new_src_q;
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (osc_ready_s && (!target_pll || pll_locked_s)) begin
                        state_q <= ST_COMMIT;
                    end
                end
                ST_COMMIT: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur_src_q <= SRC_FAST_RC_POST;
        end else if (load_now) begin
            cur_src_q <= cfg_s[CFG_INIT_LSB +: 3];
        end else if (!switch_en_q && cfg_loaded_q) begin
            cur_src_q <= init_src;
        end else if (state_q == ST_COMMIT) begin
            cur_src_q <= switch_target_q;
        end
    end

    // lock status only meaningful while a PLL mode runs undisturbed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pll_status_q <= 1'b0;
        end else begin
            pll_status_q <= cur_pll && state_q == ST_IDLE && pll_locked_s;
        end
    end

    // ==========================================================
    // oscillator enables and clock outputs
    logic sw_busy;
    logic primary_cur;
    logic primary_tgt;
    logic fast_cur;
    logic fast_tgt;
    logic internal_cur;

    assign sw_busy = state_q != ST_IDLE;
    assign primary_cur = (cur_src_q == SRC_PRIMARY || cur_src_q == SRC_PRIMARY_PLL) && pmode != PMODE_NONE;
    assign primary_tgt = sw_busy && (switch_target_q == SRC_PRIMARY || switch_target_q == SRC_PRIMARY_PLL);
    assign fast_cur = cur_src_q == SRC_FAST_RC || cur_src_q == SRC_FAST_RC_PLL || cur_src_q == SRC_FAST_RC_POST;
    assign fast_tgt = sw_busy && (switch_target_q == SRC_FAST_RC || switch_target_q == SRC_FAST_RC_PLL
        || switch_target_q == SRC_FAST_RC_POST);
    assign internal_cur = fast_cur || cur_src_q == SRC_LOW_POWER_RC || cur_src_q == SRC_SECONDARY;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_source_q <= SRC_FAST_RC_POST;
            switch_active_q <= 1'b0;
            pll_enable_q <= 1'b0;
            usb_clock_enable_q <= 1'b0;
            fast_rc_run_q <= 1'b1;
            fast_rc_div_enable_q <= 1'b1;
            primary_osc_run_q <= 1'b0;
            secondary_osc_run_q <= 1'b0;
        end else begin
            sys_source_q <= cur_src_q;
            switch_active_q <= sw_busy;
            pll_enable_q <= cur_pll || (sw_busy && target_pll);
            usb_clock_enable_q <= cur_pll && pll_status_q;
            fast_rc_run_q <= fast_cur || fast_tgt;
            fast_rc_div_enable_q <= cur_src_q == SRC_FAST_RC_POST;
            primary_osc_run_q <= (primary_cur || primary_tgt) && (!sleep_mode || keep_q);
            secondary_osc_run_q <= sec_en_q || cur_src_q == SRC_SECONDARY
                || (sw_busy && switch_target_q == SRC_SECONDARY);
        end
    end

    // instruction clock modelled as a toggle of the processor clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instruction_clock_q <= 1'b0;
        end else begin
            instruction_clock_q <= !instruction_clock_q;
        end
    end

    // pin is free for clock out only in EC mode or with an internal source
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_output_pin_q <= 1'b0;
            osc_output_pin_oe_q <= 1'b0;
        end else begin
            osc_output_pin_q <= !instruction_clock_q;
            osc_output_pin_oe_q <= (primary_cur && pmode == PMODE_EXT_CLOCK)
                || (internal_cur && cfg_q[CFG_PIN_FN_BIT]);
        end
    end

    // ==========================================================
    // register bus: read channel
    logic [31:0] rd_word;
    logic rd_hit;

    always_comb begin
        rd_word = 32'h0;
        rd_hit = 1'b1;
        case (s_axi_araddr[ADDR_W-1:2])
            OFS_OSC_CONTROL[ADDR_W-1:2]: begin
                rd_word[CUR_LSB +: 3] = cur_src_q;
                rd_word[NEW_LSB +: 3] = new_src_q;
                rd_word[BIT_SEL_LOCK] = sel_lock_q;
                rd_word[BIT_PIN_LOCK] = pin_lock_q;
                rd_word[BIT_PLL_LOCK] = pll_status_q;
                rd_word[BIT_FAIL] = fail_flag_q;
                rd_word[BIT_KEEP] = keep_q;
                rd_word[BIT_SEC_EN] = sec_en_q;
                rd_word[BIT_REQ] = req_q;
            end
            OFS_UNLOCK[ADDR_W-1:2]: begin
                rd_word[0] = unlocked_q;
            end
            OFS_CFG_STATUS[ADDR_W-1:2]: begin
                rd_word[15:0] = cfg_q;
                rd_word[16] = switch_en_q;
                rd_word[17] = monitor_enable_q;
                rd_word[18] = sw_busy;
                rd_word[19] = cfg_loaded_q;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ==========================================================
    // checks
    sequence s_ready_seen;
        state_q == ST_WAIT && osc_ready_s && (!target_pll || pll_locked_s);
    endsequence
    sequence s_commit_done;
        ##1 state_q == ST_COMMIT ##1 (state_q == ST_IDLE && cur_src_q == $past(switch_target_q) && switch_en_q);
    endsequence

    a_switch_commit: assert property (@(posedge aclk) disable iff (!aresetn)
        s_ready_seen and switch_en_q |-> s_commit_done)
        else $error("switch did not commit the target source");
    a_reserved_dropped: assert property (@(posedge aclk) disable iff (!aresetn)
        req_go && !locked_now && new_src_q == SRC_RESERVED |=> state_q == ST_IDLE && $stable(cur_src_q))
        else $error("reserved source started a switch");
    a_disabled_request: assert property (@(posedge aclk) disable iff (!aresetn)
        !switch_en_q && cfg_loaded_q |=> !req_q && cur_src_q == init_src)
        else $error("request or source moved while switching disabled");
    a_sel_lock_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        sel_lock_q && monitor_enable_q && req_q && state_q == ST_IDLE |=> state_q == ST_IDLE)
        else $error("locked selection started a switch");
    a_pin_one_way: assert property (@(posedge aclk) disable iff (!aresetn)
        pin_lock_q && cfg_q[CFG_ONE_WAY_BIT] |=> pin_lock_q)
        else $error("one-way pin lock was cleared");
    a_pll_status_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        state_q != ST_IDLE || !cur_pll |=> !pll_status_q)
        else $error("pll status set during switch or non-pll mode");
    a_fail_set: assert property (@(posedge aclk) disable iff (!aresetn)
        monitor_enable_q && fail_s |=> fail_flag_q ##1 (fail_flag_q || $past(wr_lo)))
        else $error("clock fail flag not set by monitor");
    a_fail_no_monitor: assert property (@(posedge aclk) disable iff (!aresetn)
        !monitor_enable_q |=> !$rose(fail_flag_q))
        else $error("clock fail flag set without monitor");
    a_sleep_primary: assert property (@(posedge aclk) disable iff (!aresetn)
        sleep_mode && !keep_q |=> !primary_osc_run_q)
        else $error("primary oscillator ran in sleep");
endmodule // scsc_top

/* tb.sv */
// Purpose: self-checking bench for the clock select control block
// Assumes: registers reached over AXI4-Lite, one 125 MHz clock
// Notes: config word is static, so each config case gets its own reset
`timescale 1ns/1ns
module tb
    import scsc_pkg::*;
;
// ==========================================================
// signals
logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, pll_locked = 1'h0, clock_fail_detect = 1'h0;
logic target_osc_ready = 1'h1, sleep_mode = 1'h0;
logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
logic [31:0] s_axi_wdata = 32'h0, rd_d;
logic [3:0] s_axi_wstrb = 4'hF;
logic [15:0] config_word_two = 16'hFFFF;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic secondary_osc_run_q, instruction_clock_q, monitor_enable_q;
logic switch_active_q, pll_enable_q, usb_clock_enable_q, fast_rc_run_q, fast_rc_div_enable_q, primary_osc_run_q;
logic osc_output_pin_q, osc_output_pin_oe_q;
logic [2:0] switch_target_q;
logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
logic [31:0] s_axi_rdata;
logic [2:0] sys_source_q;
int n_fail = 0, compares = 0;
always #4 aclk = ~aclk;
scsc_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .config_word_two, .pll_locked,
    .clock_fail_detect, .target_osc_ready, .sleep_mode, .sys_source_q, .switch_target_q, .switch_active_q,
    .pll_enable_q, .usb_clock_enable_q, .fast_rc_run_q, .fast_rc_div_enable_q, .primary_osc_run_q,
    .secondary_osc_run_q, .instruction_clock_q, .osc_output_pin_q, .osc_output_pin_oe_q, .monitor_enable_q);
// ==========================================================
// bus and check tasks
task close_out();
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
endtask
task chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
        n_fail++;
        $display("BAD %s exp %h got %h", nm, e, g);
    end
endtask
// bounded handshake wait; a hang ends the run through close_out
task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wready) s_axi_wvalid <= 1'h0;
        if (++n > 50) begin
            chk("write timeout", 32'h1, 32'h0);
            close_out();
        end
    end while (!(s_axi_bvalid === 1'h1));
    s_axi_bready <= 1'h0;
    @(posedge aclk);
endtask
task rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'h0;
        rd_d = s_axi_rdata;
        rd_r = s_axi_rresp;
        if (++n > 50) begin
            chk("read timeout", 32'h1, 32'h0);
            close_out();
        end
    end while (!(s_axi_rvalid === 1'h1));
    s_axi_rready <= 1'h0;
    @(posedge aclk);
endtask
// every control write needs a fresh key pair
task ctl(input logic [31:0] d);
    wr(OFS_UNLOCK, {24'h0, UNLOCK_KEY1});
    wr(OFS_UNLOCK, {24'h0, UNLOCK_KEY2});
    wr(OFS_OSC_CONTROL, d);
endtask
task rst(input logic [15:0] cfg);
    aresetn <= 1'h0;
    config_word_two <= cfg;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (6) @(posedge aclk);
endtask
task poll_req();
    int n;
    n = 0;
    do begin
        rd(OFS_OSC_CONTROL);
        if (++n > 30) begin
            chk("switch timeout", 32'h1, 32'h0);
            close_out();
        end
    end while (rd_d[0] !== 1'h0);
endtask
// ==========================================================
// scenarios
task t_erased();
    rst(16'hFFFF);
    rd(OFS_OSC_CONTROL);
    chk("ctl erased", rd_d, 32'h00007700);
    chk("src erased", {29'h0, sys_source_q}, 32'h7);
    chk("monitor off", {31'h0, monitor_enable_q}, 32'h0);
    chk("postscaler on", {31'h0, fast_rc_div_enable_q}, 32'h1);
    ctl(32'h00000001);
    rd(OFS_OSC_CONTROL);
    chk("req held", rd_d & 32'h00007001, 32'h00007000);
    rd(8'h40);
    chk("unmapped resp", {30'h0, rd_r}, {30'h0, RESP_SLVERR});
    chk("unmapped data", rd_d, 32'h0);
endtask
task t_switch();
    logic ic;
    rst(16'h0003);
    rd(OFS_OSC_CONTROL);
    chk("ctl fast rc", rd_d & 32'h0000FFFF, 32'h0);
    chk("monitor on", {31'h0, monitor_enable_q}, 32'h1);
    ctl(32'h00000403);
    poll_req();
    chk("cur second", rd_d & 32'h00007003, 32'h00004002);
    chk("sec run", {31'h0, secondary_osc_run_q}, 32'h1);
    ctl(32'h00000603);
    poll_req();
    chk("reserved", {29'h0, sys_source_q}, 32'h4);
    ctl(32'h00000482);
    ctl(32'h00000083);
    poll_req();
    chk("locked", rd_d & 32'h00007080, 32'h00004080);
    ic = instruction_clock_q;
    @(posedge aclk);
    chk("inst clk", {31'h0, instruction_clock_q}, {31'h0, ~ic});
endtask
// ext clock with pll at start, one-way pin lock, pin function set
task t_primary();
    rst(16'h0330);
    rd(OFS_OSC_CONTROL);
    chk("ctl pll start", rd_d, 32'h00003300);
    chk("primary run", {31'h0, primary_osc_run_q}, 32'h1);
    chk("fast rc off", {31'h0, fast_rc_run_q}, 32'h0);
    chk("pin oe ec", {31'h0, osc_output_pin_oe_q}, 32'h1);
    chk("pin clock", {31'h0, osc_output_pin_q}, {31'h0, instruction_clock_q});
    pll_locked <= 1'h1;
    repeat (6) @(posedge aclk);
    chk("pll en", {31'h0, pll_enable_q}, 32'h1);
    chk("usb en", {31'h0, usb_clock_enable_q}, 32'h1);
    sleep_mode <= 1'h1;
    repeat (2) @(posedge aclk);
    chk("sleep stop", {31'h0, primary_osc_run_q}, 32'h0);
    sleep_mode <= 1'h0;
    clock_fail_detect <= 1'h1;
    repeat (4) @(posedge aclk);
    clock_fail_detect <= 1'h0;
    rd(OFS_OSC_CONTROL);
    chk("fail set", rd_d, 32'h00003328);
    ctl(32'h00000340);
    rd(OFS_OSC_CONTROL);
    chk("fail clear", rd_d, 32'h00003360);
    // oscillator not ready: the switch must stay pending
    target_osc_ready <= 1'h0;
    ctl(32'h00000001);
    repeat (4) @(posedge aclk);
    chk("switch busy", {31'h0, switch_active_q}, 32'h1);
    chk("switch target", {29'h0, switch_target_q}, 32'h0);
    rd(OFS_OSC_CONTROL);
    chk("req stands", rd_d, 32'h00003041);
    target_osc_ready <= 1'h1;
    poll_req();
    chk("pin lock kept", rd_d, 32'h00000040);
    chk("src fast rc", {29'h0, sys_source_q}, 32'h0);
    chk("switch idle", {31'h0, switch_active_q}, 32'h0);
    chk("pll off", {31'h0, pll_enable_q}, 32'h0);
    chk("usb off", {31'h0, usb_clock_enable_q}, 32'h0);
    chk("fast rc on", {31'h0, fast_rc_run_q}, 32'h1);
    chk("postscaler off", {31'h0, fast_rc_div_enable_q}, 32'h0);
    chk("pin oe internal", {31'h0, osc_output_pin_oe_q}, 32'h1);
endtask
initial begin
    t_erased();
    t_switch();
    t_primary();
    close_out();
end
endmodule // tb
